// [rtl/cfsl_pkg.sv]
// package: constants and carriers for the counter function select and latch block
`default_nettype none
package cfsl_pkg;
	// wishbone register offsets (byte addresses)
	localparam logic [7:0] ctrl_off    = 8'h00;
	localparam logic [7:0] samp_off    = 8'h04;
	localparam logic [7:0] preset_off  = 8'h08;
	localparam logic [7:0] status_off  = 8'h0c;
	localparam logic [7:0] cur_lo_off  = 8'h10;
	localparam logic [7:0] cur_hi_off  = 8'h14;
	localparam logic [7:0] lat1_lo_off = 8'h18;
	localparam logic [7:0] lat1_hi_off = 8'h1c;
	localparam logic [7:0] lat2_lo_off = 8'h20;
	localparam logic [7:0] lat2_hi_off = 8'h24;
	// ctrl field positions
	localparam int ctrl_start_bit  = 0;
	localparam int ctrl_enable_bit = 1;
	localparam int ctrl_neg_bit    = 2;
	localparam int ctrl_func_lsb   = 4;
	// status field positions
	localparam int stat_sampling_bit = 0;
	localparam int stat_disabled_bit = 1;
	localparam int stat_trigger_bit  = 2;
	// reset values
	localparam logic [2:0]  func_reset = 3'h0;
	localparam logic [15:0] samp_reset = 16'h0001;
	// timing: control tick and sampling step
	localparam int clk_mhz        = 250;
	localparam int tick_us        = 1000;
	localparam int tick_cycles    = tick_us * clk_mhz;
	localparam int samp_step_ms   = 10;
	localparam int samp_min_units = 1;
	// auxiliary function selection
	typedef enum logic [2:0] {
		cfsl_latch,
		cfsl_disable,
		cfsl_sampling,
		cfsl_dis_preset,
		cfsl_lat_preset
	} cfsl_func_e;
	// configuration carrier
	typedef struct packed {
		cfsl_func_e  func;
		logic        neg_logic;
		logic        count_enable;
		logic        start_cmd;
		logic [15:0] samp_units;
		logic [31:0] preset;
	} cfsl_cfg_s;
endpackage
`default_nettype wire

// [rtl/cfsl_sync_edge.sv]
// file: two-stage input synchroniser with rising and falling edge pulses
`default_nettype none
module cfsl_sync_edge (
	// clocking
	input  wire logic core_clk,
	input  wire logic reset,
	input  wire logic clk_en,
	// pin in, clean level and edges out
	input  wire logic pin,
	output logic      level,
	output logic      rise,
	output logic      fall
);
	logic meta_reg;   // first stage, read only by the second
	logic sync_reg;   // second stage
	logic prev_reg;   // delayed copy for edge detection

	// synchroniser chain, frozen while clk_en is low
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			prev_reg <= 1'b0;
		end else if (clk_en) begin
			meta_reg <= pin;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	assign level = sync_reg;
	assign rise  = sync_reg & ~prev_reg;
	assign fall  = ~sync_reg & prev_reg;
endmodule
`default_nettype wire

// [rtl/cfsl_top.sv]
// file: counter function selection, latch capture and pulse counter with wishbone registers
//
// Overview of operation
// - five auxiliary functions, one selected at once
// - preset modes respond to function input only
// - polarity bit inverts the function input
// - sampling time in ten millisecond units
// - start command sampled on one millisecond tick
// - count disable holds count while trigger active
// - trigger rise latches count into area one
// - latch input rise latches into area two
// - latched values held until next capture
// - latches work regardless of count enable
// - latch storage updates on next millisecond tick
// - second source while first active: no capture
// - sampling restarts from zero, stops at time
// - disable-preset: stop on rise, preset on fall
`default_nettype none
module cfsl_top #(
	parameter int tick_len = cfsl_pkg::tick_cycles   // cycles per control tick
) (
	// clock, reset, enable
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire logic        clk_en,
	// wishbone classic slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	output logic             wb_err_o,
	// external pins
	input  wire logic        count_pulse_pin,
	input  wire logic        function_in_pin,
	input  wire logic        latch_in_pin,
	// status outputs
	output logic             sampling_active,
	output logic [31:0]      current_value
);
	initial begin
		if (tick_len < 2) $error("tick_len must be at least 2");
	end

	// configuration registers
	cfsl_pkg::cfsl_cfg_s cfg_reg;
	// counting state
	logic [31:0] count_reg, count_next;        // current value
	logic [31:0] latch1_reg, latch2_reg;       // storage areas
	logic [31:0] pend1_reg, pend2_reg;         // captured, awaiting tick
	logic        pend1_valid_reg, pend2_valid_reg;
	logic [31:0] tick_cnt_reg;                 // control tick divider
	logic        start_tick_reg;               // start command as seen on tick
	logic        trig_prev_reg;                // combined trigger last cycle
	logic        samp_run_reg;                 // sampling window open
	logic [15:0] samp_units_left_reg;          // 10 ms units remaining
	logic [3:0]  samp_ms_reg;                  // ms within current unit
	logic        ack_reg;
	logic        err_reg;
	logic [31:0] rdata_reg;

	// synchronised pins
	logic pulse_lvl, pulse_rise, pulse_fall;
	logic fin_lvl, fin_rise, fin_fall;
	logic lin_lvl, lin_rise, lin_fall;

	cfsl_sync_edge u_pulse (
		.core_clk (core_clk),
		.reset    (reset),
		.clk_en   (clk_en),
		.pin      (count_pulse_pin),
		.level    (pulse_lvl),
		.rise     (pulse_rise),
		.fall     (pulse_fall)
	);
	cfsl_sync_edge u_fin (
		.core_clk (core_clk),
		.reset    (reset),
		.clk_en   (clk_en),
		.pin      (function_in_pin),
		.level    (fin_lvl),
		.rise     (),
		.fall     ()
	);
	cfsl_sync_edge u_lin (
		.core_clk (core_clk),
		.reset    (reset),
		.clk_en   (clk_en),
		.pin      (latch_in_pin),
		.level    (),
		.rise     (lin_rise),
		.fall     ()
	);

	// control tick strobe, one cycle every millisecond
	wire tick = (tick_cnt_reg == 32'(tick_len - 1));

	// function input after polarity adjust
	wire fin_active = fin_lvl ^ cfg_reg.neg_logic;
	// preset modes ignore the program start command
	wire preset_mode = (cfg_reg.func == cfsl_pkg::cfsl_dis_preset) ||
	                   (cfg_reg.func == cfsl_pkg::cfsl_lat_preset);
	wire cmd_term    = start_tick_reg & ~preset_mode;
	// combined trigger; second source while first is on makes no new edge
	wire trig        = cmd_term | fin_active;
	wire trig_rise   = trig & ~trig_prev_reg;
	wire trig_fall   = ~trig & trig_prev_reg;

	// mode decode
	wire is_latch    = (cfg_reg.func == cfsl_pkg::cfsl_latch) ||
	                   (cfg_reg.func == cfsl_pkg::cfsl_lat_preset);
	wire is_disable  = (cfg_reg.func == cfsl_pkg::cfsl_disable) ||
	                   (cfg_reg.func == cfsl_pkg::cfsl_dis_preset);
	wire is_sampling = (cfg_reg.func == cfsl_pkg::cfsl_sampling);

	// counting gate: disable modes hold while trigger is active
	wire disabled    = is_disable & trig;
	wire count_ok    = is_sampling ? samp_run_reg : (cfg_reg.count_enable & ~disabled);
	// preset loads on falling edge in both preset modes
	wire preset_load = preset_mode & trig_fall;
	wire samp_start  = is_sampling & trig_rise;
	wire samp_done   = samp_run_reg && tick && (samp_ms_reg == 4'(cfsl_pkg::samp_step_ms - 1))
	                   && (samp_units_left_reg == 16'h0001);

	// next count value; pulse_fall unused so one edge per input pulse
	always_comb begin
		count_next = count_reg;
		if (samp_start) begin
			count_next = 32'h0000_0000;
		end else if (preset_load) begin
			count_next = cfg_reg.preset;
		end else if (pulse_rise && count_ok) begin
			count_next = count_reg + 32'h0000_0001;
		end
	end

	// tick divider and start command sampling on tick
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			tick_cnt_reg   <= 32'h0000_0000;
			start_tick_reg <= 1'b0;
		end else if (clk_en) begin
			tick_cnt_reg <= tick ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
			if (tick) begin
				start_tick_reg <= cfg_reg.start_cmd;
			end
		end
	end

	// counter and trigger history
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			count_reg     <= 32'h0000_0000;
			trig_prev_reg <= 1'b0;
		end else if (clk_en) begin
			count_reg     <= count_next;
			trig_prev_reg <= trig;
		end
	end

	// sampling window timing, counted in ms then 10 ms units
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			samp_run_reg        <= 1'b0;
			samp_units_left_reg <= 16'h0000;
			samp_ms_reg         <= 4'h0;
		end else if (clk_en) begin
			if (samp_start && !samp_run_reg) begin
				// a retrigger during a window only zeroes the count
				samp_run_reg        <= 1'b1;
				samp_units_left_reg <= cfg_reg.samp_units;
				samp_ms_reg         <= 4'h0;
			end else if (samp_done || !is_sampling) begin
				samp_run_reg <= 1'b0;
			end else if (samp_run_reg && tick) begin
				if (samp_ms_reg == 4'(cfsl_pkg::samp_step_ms - 1)) begin
					samp_ms_reg         <= 4'h0;
					samp_units_left_reg <= samp_units_left_reg - 16'h0001;
				end else begin
					samp_ms_reg <= samp_ms_reg + 4'h1;
				end
			end
		end
	end

	// latch capture: snapshot now, publish on next tick
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pend1_reg       <= 32'h0000_0000;
			pend2_reg       <= 32'h0000_0000;
			pend1_valid_reg <= 1'b0;
			pend2_valid_reg <= 1'b0;
			latch1_reg      <= 32'h0000_0000;
			latch2_reg      <= 32'h0000_0000;
		end else if (clk_en) begin
			// capture ignores count enable on purpose
			if (is_latch && trig_rise) begin
				pend1_reg       <= count_reg;
				pend1_valid_reg <= 1'b1;
			end else if (tick) begin
				pend1_valid_reg <= 1'b0;
			end
			if (lin_rise) begin
				pend2_reg       <= count_reg;
				pend2_valid_reg <= 1'b1;
			end else if (tick) begin
				pend2_valid_reg <= 1'b0;
			end
			// storage held until a later capture overwrites it
			if (tick && pend1_valid_reg) begin
				latch1_reg <= pend1_reg;
			end
			if (tick && pend2_valid_reg) begin
				latch2_reg <= pend2_reg;
			end
		end
	end

	// bus decode
	wire req      = wb_cyc_i & wb_stb_i & ~ack_reg & ~err_reg;
	wire hit_ctrl = (wb_adr_i == cfsl_pkg::ctrl_off);
	wire hit_samp = (wb_adr_i == cfsl_pkg::samp_off);
	wire hit_pre  = (wb_adr_i == cfsl_pkg::preset_off);
	wire [31:0] ctrl_word = {25'h0, cfg_reg.func, 1'b0, cfg_reg.neg_logic,
	                         cfg_reg.count_enable, cfg_reg.start_cmd};
	wire [31:0] stat_word = {29'h0, trig, disabled, samp_run_reg};
	logic [31:0] rsel;
	logic        mapped;
	// read mux; counts split into 16-bit words
	always_comb begin
		mapped = 1'b1;
		rsel   = 32'h0000_0000;
		if (hit_ctrl) begin
			rsel = ctrl_word;
		end else if (hit_samp) begin
			rsel = {16'h0000, cfg_reg.samp_units};
		end else if (hit_pre) begin
			rsel = cfg_reg.preset;
		end else if (wb_adr_i == cfsl_pkg::status_off) begin
			rsel = stat_word;
		end else if (wb_adr_i == cfsl_pkg::cur_lo_off) begin
			rsel = {16'h0000, count_reg[15:0]};
		end else if (wb_adr_i == cfsl_pkg::cur_hi_off) begin
			rsel = {16'h0000, count_reg[31:16]};
		end else if (wb_adr_i == cfsl_pkg::lat1_lo_off) begin
			rsel = {16'h0000, latch1_reg[15:0]};
		end else if (wb_adr_i == cfsl_pkg::lat1_hi_off) begin
			rsel = {16'h0000, latch1_reg[31:16]};
		end else if (wb_adr_i == cfsl_pkg::lat2_lo_off) begin
			rsel = {16'h0000, latch2_reg[15:0]};
		end else if (wb_adr_i == cfsl_pkg::lat2_hi_off) begin
			rsel = {16'h0000, latch2_reg[31:16]};
		end else begin
			mapped = 1'b0;
		end
	end

	// register writes and bus answer, one wait-free cycle
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			cfg_reg.func         <= cfsl_pkg::cfsl_func_e'(cfsl_pkg::func_reset);
			cfg_reg.neg_logic    <= 1'b0;
			cfg_reg.count_enable <= 1'b0;
			cfg_reg.start_cmd    <= 1'b0;
			cfg_reg.samp_units   <= cfsl_pkg::samp_reset;
			cfg_reg.preset       <= 32'h0000_0000;
			ack_reg              <= 1'b0;
			err_reg              <= 1'b0;
			rdata_reg            <= 32'h0000_0000;
		end else if (clk_en) begin
			ack_reg   <= req & mapped;
			err_reg   <= req & ~mapped;
			rdata_reg <= rsel;
			if (req && wb_we_i && hit_ctrl && wb_sel_i[0]) begin
				cfg_reg.start_cmd    <= wb_dat_i[cfsl_pkg::ctrl_start_bit];
				cfg_reg.count_enable <= wb_dat_i[cfsl_pkg::ctrl_enable_bit];
				cfg_reg.neg_logic    <= wb_dat_i[cfsl_pkg::ctrl_neg_bit];
				// unknown codes fall back to latch mode
				if (wb_dat_i[cfsl_pkg::ctrl_func_lsb +: 3] <= 3'h4) begin
					cfg_reg.func <= cfsl_pkg::cfsl_func_e'(wb_dat_i[cfsl_pkg::ctrl_func_lsb +: 3]);
				end else begin
					cfg_reg.func <= cfsl_pkg::cfsl_latch;
				end
			end
			// zero sampling time would wrap and run 65536 units, so floor at one unit
			if (req && wb_we_i && hit_samp && (wb_sel_i[1:0] == 2'b11)) begin
				cfg_reg.samp_units <= (wb_dat_i[15:0] == 16'h0000) ?
				                      16'(cfsl_pkg::samp_min_units) : wb_dat_i[15:0];
			end
			if (req && wb_we_i && hit_pre && (wb_sel_i == 4'hf)) begin
				cfg_reg.preset <= wb_dat_i;
			end
		end
	end

	assign wb_ack_o        = ack_reg;
	assign wb_err_o        = err_reg;
	assign wb_dat_o        = rdata_reg;
	assign sampling_active = samp_run_reg;
	assign current_value   = count_reg;
endmodule
`default_nettype wire

// [tb/cfsl_top_props.sv]
// checker: bus answers, count stability and sampling window of the block
`default_nettype none
module cfsl_top_props #(
	parameter int tick_len = 20  // cycles per control tick
) (
	// clock and reset
	input wire logic        core_clk,
	input wire logic        reset,
	input wire logic        clk_en,
	// bus
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic        wb_ack_o,
	input wire logic        wb_err_o,
	// pins and status
	input wire logic        count_pulse_pin,
	input wire logic        function_in_pin,
	input wire logic        latch_in_pin,
	input wire logic        sampling_active,
	input wire logic [31:0] current_value
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// a request counts only while no answer stands
	wire         take   = wb_cyc_i & wb_stb_i & clk_en & ~wb_ack_o & ~wb_err_o;
	wire         mapped = (wb_adr_i[1:0] == 2'h0) && (wb_adr_i <= 8'h24);
	wire  [2:0]  pins   = {count_pulse_pin, function_in_pin, latch_in_pin};
	logic [2:0]  pins_reg;   // pin levels one cycle back
	logic [15:0] quiet_cnt;  // idle cycles; must outlast sync delay plus one tick
	logic [15:0] open_cnt;   // cycles the window has stayed open
	// helper counters
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pins_reg  <= 3'h0;
			quiet_cnt <= 16'h0;
			open_cnt  <= 16'h0;
		end else begin
			pins_reg  <= pins;
			quiet_cnt <= (wb_cyc_i || pins_reg != pins) ? 16'h0 : quiet_cnt + 16'h1;
			open_cnt  <= sampling_active ? open_cnt + 16'h1 : 16'h0;
		end
	end
	sequence s_take; take; endsequence
	sequence s_answer; wb_ack_o || wb_err_o; endsequence
	property p_answer; s_take |=> s_answer; endproperty
	property p_one_shot; s_answer |=> !(wb_ack_o || wb_err_o); endproperty
	property p_caused; s_answer |-> $past(take); endproperty
	property p_ack_map; wb_ack_o |-> mapped; endproperty
	property p_err_map; wb_err_o |-> !mapped; endproperty
	property p_still; quiet_cnt > tick_len + 8 |-> $stable(current_value); endproperty
	property p_win_len; $fell(sampling_active) |-> open_cnt >= 9 * tick_len; endproperty
	property p_win_zero; $rose(sampling_active) |-> ##[0:2] current_value < 32'h2; endproperty
	property p_rst; $fell(reset) |-> current_value == 32'h0 && !sampling_active; endproperty
	a_answer: assert property (p_answer) else $error("no answer after request");
	a_one_shot: assert property (p_one_shot) else $error("answer longer than one cycle");
	a_caused: assert property (p_caused) else $error("answer without request");
	a_ack_map: assert property (p_ack_map) else $error("ack on unmapped address");
	a_err_map: assert property (p_err_map) else $error("err on mapped address");
	a_still: assert property (p_still) else $error("count moved with no cause");
	a_win_len: assert property (p_win_len) else $error("sampling window too short");
	a_win_zero: assert property (p_win_zero) else $error("window opened without zeroing");
	a_rst: assert property (p_rst) else $error("state not clear after reset");
endmodule
bind cfsl_top cfsl_top_props #(.tick_len(tick_len)) cfsl_top_props_i (
	.core_clk(core_clk), .reset(reset), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .count_pulse_pin(count_pulse_pin),
	.function_in_pin(function_in_pin), .latch_in_pin(latch_in_pin),
	.sampling_active(sampling_active), .current_value(current_value));
`default_nettype wire

// [tb/cfsl_ext_model.sv]
// model: external pulse source, function input and latch input
`default_nettype none
module cfsl_ext_model (
	// clock
	input  wire logic core_clk,
	// levels asked for by the bench
	input  wire logic func_on,
	input  wire logic latch_on,
	input  wire logic neg_logic,
	// pins into the block
	output var logic  count_pulse_pin,
	output logic      function_in_pin,
	output logic      latch_in_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// under negative logic the active level is no voltage
	assign function_in_pin = func_on ^ neg_logic;
	assign latch_in_pin = latch_on;
	initial count_pulse_pin = 1'b0;
	// pulses four cycles high, four low, so the synchroniser never misses one
	task automatic send(input int n);
		repeat (n) begin
			count_pulse_pin <= 1'b1;
			repeat (4) @(posedge core_clk);
			count_pulse_pin <= 1'b0;
			repeat (4) @(posedge core_clk);
		end
	endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// bench: register, latch, disable, sampling, preset and reset tests of the function select and latch block
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int tick_len = 20;  // short tick keeps the run brief
	logic        core_clk, reset, clk_en, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, current_value, rd;
	logic        count_pulse_pin, function_in_pin, latch_in_pin, sampling_active, func_on, latch_on, neg_logic;
	int          err_total, checks_done, n;
	cfsl_top #(.tick_len(tick_len)) cfsl_top_i (.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
		.count_pulse_pin(count_pulse_pin), .function_in_pin(function_in_pin), .latch_in_pin(latch_in_pin),
		.sampling_active(sampling_active), .current_value(current_value));
	cfsl_ext_model cfsl_ext_model_i (.core_clk(core_clk), .func_on(func_on), .latch_on(latch_on),
		.neg_logic(neg_logic), .count_pulse_pin(count_pulse_pin), .function_in_pin(function_in_pin),
		.latch_in_pin(latch_in_pin));
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// one classic cycle: request held until the answer edge, then one idle cycle
	task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int k;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && k < 20);
		rd = wb_err_o ? 32'hffffffff : wb_dat_o;  // an error answer reads as all ones here
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
		@(posedge core_clk);
		if (k >= 20) begin
			err_total++;
			$display("FAIL at %0t: bus hang", $time);
			wrap_up();
		end
	endtask
	task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
		bus(1'b0, adr, 32'h0);
		check(rd, exp);
	endtask
	// counts travel as two 16-bit words, low first
	task automatic rd32(input logic [7:0] adr, input logic [31:0] exp);
		bus(1'b0, adr, 32'h0);
		check({16'h0, rd[15:0]}, {16'h0, exp[15:0]});
		bus(1'b0, adr + 8'h4, 32'h0);
		check({16'h0, rd[15:0]}, {16'h0, exp[31:16]});
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge core_clk);
	endtask
	initial begin
		{reset, clk_en, wb_cyc_i, wb_stb_i, wb_we_i, func_on, latch_on, neg_logic} = 8'hc0;
		{wb_adr_i, wb_sel_i, wb_dat_i} = '0;
		err_total = 0;
		checks_done = 0;
		cyc(10);
		reset <= 1'b0;
		wb_sel_i <= 4'hf;
		cyc(1);
		rdchk(cfsl_pkg::ctrl_off, 32'h0);
		rdchk(cfsl_pkg::samp_off, 32'h1);
		for (int f = 0; f < 6; f++) begin
			bus(1'b1, cfsl_pkg::ctrl_off, 32'(f == 5 ? 7 : f) << 4);
			rdchk(cfsl_pkg::ctrl_off, 32'(f == 5 ? 0 : f) << 4);
		end
		rdchk(8'h30, 32'hffffffff);
		$display("test registers done");
		bus(1'b1, cfsl_pkg::ctrl_off, 32'h2);
		cfsl_ext_model_i.send(5);
		rd32(cfsl_pkg::cur_lo_off, 32'h5);
		func_on <= 1'b1;
		cyc(tick_len + 6);
		rd32(cfsl_pkg::lat1_lo_off, 32'h5);
		cfsl_ext_model_i.send(2);
		bus(1'b1, cfsl_pkg::ctrl_off, 32'h3);
		cyc(2 * tick_len);
		rd32(cfsl_pkg::lat1_lo_off, 32'h5);
		bus(1'b1, cfsl_pkg::ctrl_off, 32'h0);
		func_on <= 1'b0;
		latch_on <= 1'b1;
		cfsl_ext_model_i.send(2);
		cyc(tick_len + 6);
		rd32(cfsl_pkg::lat2_lo_off, 32'h7);
		rd32(cfsl_pkg::cur_lo_off, 32'h7);
		latch_on <= 1'b0;
		bus(1'b1, cfsl_pkg::ctrl_off, 32'h1);
		cyc(2 * tick_len + 4);
		rd32(cfsl_pkg::lat1_lo_off, 32'h7);
		$display("test latch done");
		neg_logic <= 1'b1;
		bus(1'b1, cfsl_pkg::ctrl_off, 32'h16);
		func_on <= 1'b1;
		cyc(4);
		cfsl_ext_model_i.send(3);
		rd32(cfsl_pkg::cur_lo_off, 32'h7);
		func_on <= 1'b0;
		cyc(4);
		cfsl_ext_model_i.send(3);
		rd32(cfsl_pkg::cur_lo_off, 32'ha);
		// clock enable low freezes the synchronisers and the counter
		clk_en <= 1'b0;
		cfsl_ext_model_i.send(3);
		clk_en <= 1'b1;
		cyc(4);
		rd32(cfsl_pkg::cur_lo_off, 32'ha);
		// a write with no byte enables is acked but changes nothing
		wb_sel_i <= 4'h0;
		bus(1'b1, cfsl_pkg::ctrl_off, 32'h0);
		wb_sel_i <= 4'hf;
		rdchk(cfsl_pkg::ctrl_off, 32'h16);
		$display("test disable done");
		bus(1'b1, cfsl_pkg::ctrl_off, 32'h24);
		bus(1'b1, cfsl_pkg::samp_off, 32'h0);
		rdchk(cfsl_pkg::samp_off, 32'h1);
		func_on <= 1'b1;
		cyc(6);
		check({31'h0, sampling_active}, 32'h1);
		cfsl_ext_model_i.send(4);
		for (n = 0; n < 400 && sampling_active !== 1'b0; n++) cyc(1);
		cfsl_ext_model_i.send(2);
		rd32(cfsl_pkg::cur_lo_off, 32'h4);
		if (n >= 400) begin
			err_total++;
			$display("FAIL at %0t: sampling window never closed", $time);
			wrap_up();
		end
		func_on <= 1'b0;
		$display("test sampling done");
		bus(1'b1, cfsl_pkg::preset_off, 32'h00010100);
		bus(1'b1, cfsl_pkg::ctrl_off, 32'h36);
		func_on <= 1'b1;
		cyc(4);
		cfsl_ext_model_i.send(2);
		func_on <= 1'b0;
		cyc(6);
		rd32(cfsl_pkg::cur_lo_off, 32'h00010100);
		bus(1'b1, cfsl_pkg::ctrl_off, 32'h37);
		cyc(2 * tick_len);
		cfsl_ext_model_i.send(2);
		rd32(cfsl_pkg::cur_lo_off, 32'h00010102);
		bus(1'b1, cfsl_pkg::ctrl_off, 32'h46);
		func_on <= 1'b1;
		cyc(tick_len + 6);
		rd32(cfsl_pkg::lat1_lo_off, 32'h00010102);
		func_on <= 1'b0;
		cyc(6);
		rd32(cfsl_pkg::cur_lo_off, 32'h00010100);
		$display("test preset done");
		// second reset in mid-run returns every register to its reset value
		reset <= 1'b1;
		cyc(2);
		reset <= 1'b0;
		cyc(1);
		rdchk(cfsl_pkg::ctrl_off, 32'h0);
		rd32(cfsl_pkg::cur_lo_off, 32'h0);
		$display("test reset done");
		wrap_up();
	end
endmodule
`default_nettype wire
